// >>> snt_pkg.sv
// Shared constants for the sensor two-wire target and its controller.
// Assumes a 20 MHz system clock on both ends.
package snt_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned LOAD_TIME_US = 1500;
  localparam int unsigned PROG_TIME_US = 7000;
  localparam int unsigned TIMEOUT_US = 35000;
  localparam int unsigned LOAD_CYC = LOAD_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PROG_CYC = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);
  // Controller serial clock: 100 kHz, well inside 1 kHz..400 kHz
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam int unsigned QTR_CYC = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
  typedef logic [19:0] snt_cnt_t;

  // Target register map, indexed by the pointer
  localparam int unsigned NUM_REGS = 9;
  localparam logic [7:0] PTR_TEMP = 8'h00;
  localparam logic [7:0] PTR_CFG = 8'h01;
  localparam logic [7:0] PTR_HIGH = 8'h02;
  localparam logic [7:0] PTR_LOW = 8'h03;
  localparam logic [7:0] PTR_UNLOCK = 8'h04;
  localparam logic [7:0] PTR_GP1 = 8'h05;
  localparam logic [7:0] PTR_LAST = 8'h08;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int unsigned UNLOCK_BIT = 15;
  localparam int unsigned BUSY_BIT = 14;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] CFG_DEFAULT = 16'h0220;
  localparam logic [15:0] HIGH_DEFAULT = 16'h6000;
  localparam logic [15:0] LOW_DEFAULT = 16'h8000;
  localparam logic [15:0] GP_DEFAULT = 16'h0000;

  // Bus addressing
  localparam logic [6:0] TARGET_BASE = 7'h48;
  localparam logic [7:0] GCALL_BYTE = 8'h00;
  localparam logic [7:0] GCALL_RESET = 8'h06;

  // Controller registers (AXI4-Lite byte offsets)
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_WDATA = 8'h04;
  localparam logic [7:0] HR_TADDR = 8'h08;
  localparam logic [7:0] HR_STATUS = 8'h0c;
  localparam logic [7:0] HR_RDATA = 8'h10;
  localparam int unsigned CMD_PTR_LSB = 8;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_NACK_BIT = 1;
  localparam logic [6:0] TADDR_RESET = TARGET_BASE;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Controller command kinds
  typedef enum logic [1:0] {
    K_WRITE = 2'b00,
    K_POINTER = 2'b01,
    K_READ = 2'b10,
    K_GCALL = 2'b11
  } snt_kind_e;

  // Factory contents of the non-volatile store
  function automatic logic [15:0] snt_nvm_default(input logic [7:0] idx);
    case (idx)
      PTR_CFG: snt_nvm_default = CFG_DEFAULT;
      PTR_HIGH: snt_nvm_default = HIGH_DEFAULT;
      PTR_LOW: snt_nvm_default = LOW_DEFAULT;
      PTR_TEMP, PTR_UNLOCK: snt_nvm_default = REG_RESET;
      default: snt_nvm_default = GP_DEFAULT;
    endcase
  endfunction

endpackage

// >>> snt_bus_if.sv
// Two-wire link between controller and sensor target.
// Assumes pull-ups: a line is low only while some end enables its driver.
`timescale 1ns/10ps
interface snt_bus_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND resolution of the open-drain lines
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o, output host_sda_oe_n);
endinterface

// >>> snt_target.sv
// Sensor two-wire target with pointer, word registers and non-volatile load.
// Assumes the link lines come from another domain and the strap is static.
`timescale 1ns/10ps
module snt_target
  import snt_pkg::*;
#(
  parameter int unsigned LOAD_CYCLES = LOAD_CYC,
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // Two-wire link
  snt_bus_if.dev LINK,
  // Strap and sensor side
  input wire logic [1:0] ADDR_SEL_IN,
  input wire logic [15:0] TEMP_IN,
  // Status
  output logic NVM_BUSY_OUT,
  output logic NVM_UNLOCK_OUT,
  output logic [15:0] CONFIG_OUT
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_ACK = 3'b010,
    S_TX = 3'b011,
    S_TXACK = 3'b100
  } snt_state_e;
  typedef enum logic [2:0] {
    RK_ADDR = 3'b000,
    RK_PTR = 3'b001,
    RK_DHI = 3'b010,
    RK_DLO = 3'b011,
    RK_GCALL = 3'b100
  } snt_rxkind_e;

  logic [3:0] in_s1_q, in_s2_q, in_s3_q, filt_q;
  logic scl_prev_q, sda_prev_q;
  snt_state_e state_q;
  snt_rxkind_e kind_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, tx_q, wr_hi_q, ptr_q;
  logic go_tx_q, lo_q, sda_rel_q, wr_stb_q, soft_rst_q;
  logic [15:0] wr_data_q;
  snt_cnt_t to_cnt_q, load_cnt_q, prog_cnt_q;
  logic loading_q, prog_q, unlock_q;
  logic [15:0] vol_q [NUM_REGS];
  logic [15:0] nvm_q [NUM_REGS];
  logic scl_f, sda_f, start_ev, stop_ev, scl_rise, scl_fall, timeout, busy, rx_ack;
  logic [6:0] my_addr;
  logic [15:0] rd_word;
  logic [7:0] next_byte;
  logic in_map, nvm_backed, load_done;

  // Three-stage sampling of strap and lines; a bit moves once stages two and three agree
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      in_s1_q <= 4'hf;
      in_s2_q <= 4'hf;
      in_s3_q <= 4'hf;
      filt_q <= 4'hf;
    end else begin
      in_s1_q <= {ADDR_SEL_IN, LINK.scl, LINK.sda};
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      filt_q <= (in_s2_q & in_s3_q) | (filt_q & (in_s2_q ^ in_s3_q));
    end
  end

  // Edge history of the filtered lines
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= filt_q[1];
      sda_prev_q <= filt_q[0];
    end
  end

  // Bus conditions and decode
  assign scl_f = filt_q[1];
  assign sda_f = filt_q[0];
  assign start_ev = scl_f && scl_prev_q && sda_prev_q && !sda_f;
  assign stop_ev = scl_f && scl_prev_q && !sda_prev_q && sda_f;
  assign scl_rise = scl_f && !scl_prev_q;
  assign scl_fall = !scl_f && scl_prev_q;
  assign my_addr = TARGET_BASE | {5'h00, filt_q[3:2]};
  assign timeout = to_cnt_q == snt_cnt_t'(TIMEOUT_CYCLES - 1);
  assign busy = loading_q | prog_q;
  assign in_map = ptr_q <= PTR_LAST;
  assign nvm_backed = in_map && ptr_q != PTR_TEMP && ptr_q != PTR_UNLOCK;
  assign load_done = loading_q && load_cnt_q == snt_cnt_t'(LOAD_CYCLES - 1);
  // Only a foreign address is refused; general call is taken for writes only
  assign rx_ack = kind_q != RK_ADDR || shift_q[7:1] == my_addr || shift_q == GCALL_BYTE;
  assign next_byte = lo_q ? rd_word[7:0] : rd_word[15:8];

  // Read mux: served regardless of the load sequence
  always_comb begin
    rd_word = REG_RESET;
    if (ptr_q == PTR_TEMP) begin
      rd_word = TEMP_IN;
    end else if (ptr_q == PTR_UNLOCK) begin
      rd_word[UNLOCK_BIT] = unlock_q;
      rd_word[BUSY_BIT] = busy;
    end else if (in_map) begin
      rd_word = vol_q[ptr_q[3:0]];
    end
  end

  // Bus state machine; a STOP or the stuck-line timeout always wins
  always_ff @(posedge CLOCK_IN) begin
    wr_stb_q <= 1'b0;
    soft_rst_q <= 1'b0;
    if (!RST_N_IN) begin
      state_q <= S_IDLE;
      kind_q <= RK_ADDR;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      wr_hi_q <= 8'h00;
      ptr_q <= PTR_RESET;
      go_tx_q <= 1'b0;
      lo_q <= 1'b0;
      sda_rel_q <= 1'b1;
      wr_data_q <= REG_RESET;
    end else if (stop_ev || timeout) begin
      state_q <= S_IDLE;
      sda_rel_q <= 1'b1;
    end else if (start_ev) begin
      state_q <= S_RX;
      kind_q <= RK_ADDR;
      cnt_q <= 4'h0;
      sda_rel_q <= 1'b1;
    end else begin
      case (state_q)
        S_RX: begin
          if (scl_rise && cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_f};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            state_q <= rx_ack ? S_ACK : S_IDLE;
            sda_rel_q <= !rx_ack;
            case (kind_q)
              RK_ADDR: begin
                go_tx_q <= shift_q[0] && shift_q[7:1] == my_addr;
                lo_q <= 1'b0;
                kind_q <= shift_q == GCALL_BYTE ? RK_GCALL : RK_PTR;
              end
              RK_PTR: begin
                ptr_q <= shift_q;
                kind_q <= RK_DHI;
              end
              RK_DHI: begin
                wr_hi_q <= shift_q;
                kind_q <= RK_DLO;
              end
              RK_DLO: begin
                wr_data_q <= {wr_hi_q, shift_q};
                wr_stb_q <= 1'b1;
                kind_q <= RK_DHI;
              end
              RK_GCALL: begin
                if (shift_q == GCALL_RESET) begin
                  soft_rst_q <= 1'b1;
                  ptr_q <= PTR_RESET;
                end
              end
              default: kind_q <= RK_ADDR;
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            cnt_q <= go_tx_q ? 4'h1 : 4'h0;
            state_q <= go_tx_q ? S_TX : S_RX;
            sda_rel_q <= go_tx_q ? next_byte[7] : 1'b1;
            tx_q <= {next_byte[6:0], 1'b0};
            lo_q <= !lo_q;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            state_q <= cnt_q == 4'h8 ? S_TXACK : S_TX;
            sda_rel_q <= cnt_q == 4'h8 ? 1'b1 : tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        S_TXACK: begin
          // Not-acknowledge ends the read; a stray tail is ignored until START
          if (scl_rise && sda_f) begin
            state_q <= S_IDLE;
          end else if (scl_fall) begin
            state_q <= S_TX;
            cnt_q <= 4'h1;
            sda_rel_q <= next_byte[7];
            tx_q <= {next_byte[6:0], 1'b0};
            lo_q <= !lo_q;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Stuck-line timer: clock low or our own data low while a transfer is open
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN || state_q == S_IDLE || timeout || (scl_f && sda_rel_q)) begin
      to_cnt_q <= '0;
    end else begin
      to_cnt_q <= to_cnt_q + snt_cnt_t'(1);
    end
  end

  // Load sequence after power-on or general-call reset
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN || soft_rst_q) begin
      loading_q <= 1'b1;
      load_cnt_q <= '0;
    end else if (load_done) begin
      loading_q <= 1'b0;
    end else if (loading_q) begin
      load_cnt_q <= load_cnt_q + snt_cnt_t'(1);
    end
  end

  // Volatile registers and the unlock bit
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      unlock_q <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
        vol_q[i] <= REG_RESET;
      end
    end else if (soft_rst_q) begin
      unlock_q <= 1'b0;
    end else if (load_done) begin
      vol_q <= nvm_q;
    end else if (wr_stb_q && !prog_q) begin
      if (ptr_q == PTR_UNLOCK) begin
        unlock_q <= wr_data_q[UNLOCK_BIT];
      end else if (nvm_backed && !(loading_q && ptr_q <= PTR_LOW)) begin
        vol_q[ptr_q[3:0]] <= wr_data_q;
      end
    end
  end

  // Non-volatile store; contents only follow the chip reset, not the general call
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      prog_q <= 1'b0;
      prog_cnt_q <= '0;
      for (int i = 0; i < NUM_REGS; i++) begin
        nvm_q[i] <= snt_nvm_default(8'(i));
      end
    end else if (prog_q) begin
      prog_q <= prog_cnt_q != snt_cnt_t'(PROG_CYCLES - 1);
      prog_cnt_q <= prog_cnt_q + snt_cnt_t'(1);
    end else if (wr_stb_q && unlock_q && nvm_backed && !loading_q) begin
      nvm_q[ptr_q[3:0]] <= wr_data_q;
      prog_q <= 1'b1;
      prog_cnt_q <= '0;
    end
  end

  // Registered status outputs
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      NVM_BUSY_OUT <= 1'b0;
      NVM_UNLOCK_OUT <= 1'b0;
      CONFIG_OUT <= REG_RESET;
    end else begin
      NVM_BUSY_OUT <= busy;
      NVM_UNLOCK_OUT <= unlock_q;
      CONFIG_OUT <= vol_q[PTR_CFG[3:0]];
    end
  end

  // Open drain: only ever pull low
  assign LINK.dev_sda_o = 1'b0;
  assign LINK.dev_sda_oe_n = sda_rel_q;

endmodule

// >>> snt_controller.sv
// Two-wire bus controller commanded over AXI4-Lite.
// Assumes one target on the link and software that polls the busy bit.
`timescale 1ns/10ps
module snt_controller
  import snt_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // Two-wire link
  snt_bus_if.host LINK
);

  typedef enum logic [1:0] {H_IDLE = 2'b00, H_START = 2'b01, H_BYTE = 2'b10, H_STOP = 2'b11} snt_hstate_e;

  logic aw_got_q, w_got_q, go_q, nack_q, scl_rel_q, sda_rel_q;
  logic [7:0] awaddr_q, ptr_q, sh_q, rx_q, qcnt_q;
  logic [31:0] wbus_q;
  logic [3:0] wstrb_q, bit_q;
  logic [6:0] taddr_q;
  logic [15:0] wdata_q, rdata_q;
  logic [2:0] sda_s_q;
  logic sda_f_q;
  logic [1:0] q_q;
  logic [2:0] bi_q;
  snt_kind_e kind_q;
  snt_hstate_e st_q;
  logic tick, rd_phase, last_byte;

  // Byte sequence of each command
  function automatic logic [7:0] byte_at(input logic [2:0] i);
    case (i)
      3'd0: byte_at = kind_q == K_GCALL ? GCALL_BYTE : {taddr_q, 1'b0};
      3'd1: byte_at = kind_q == K_GCALL ? GCALL_RESET : ptr_q;
      3'd2: byte_at = kind_q == K_READ ? {taddr_q, 1'b1} : wdata_q[15:8];
      3'd3: byte_at = wdata_q[7:0];
      default: byte_at = 8'hff;
    endcase
  endfunction

  assign tick = qcnt_q == 8'(QTR_CYC - 1);
  assign rd_phase = kind_q == K_READ && bi_q >= 3'd3;
  assign last_byte = bi_q == (kind_q == K_WRITE ? 3'd3 : kind_q == K_READ ? 3'd4 : 3'd1);

  // AXI write side: address and data in either order, answer after both
  always_ff @(posedge CLOCK_IN) begin
    go_q <= 1'b0;
    S_AXI_AWREADY_OUT <= 1'b0;
    S_AXI_WREADY_OUT <= 1'b0;
    if (!RST_N_IN) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wbus_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= RESP_OKAY;
      taddr_q <= TADDR_RESET;
      wdata_q <= 16'h0000;
      ptr_q <= 8'h00;
      kind_q <= K_WRITE;
    end else begin
      if (S_AXI_AWVALID_IN && !aw_got_q && !S_AXI_AWREADY_OUT) begin
        S_AXI_AWREADY_OUT <= 1'b1;
        aw_got_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && !w_got_q && !S_AXI_WREADY_OUT) begin
        S_AXI_WREADY_OUT <= 1'b1;
        w_got_q <= 1'b1;
        wbus_q <= S_AXI_WDATA_IN;
        wstrb_q <= S_AXI_WSTRB_IN;
      end
      if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end else if (aw_got_q && w_got_q && !S_AXI_BVALID_OUT) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= RESP_OKAY;
        case (awaddr_q)
          // A command while a transfer is running is dropped
          HR_CMD: if (wstrb_q[0] && st_q == H_IDLE) begin
            kind_q <= snt_kind_e'(wbus_q[1:0]);
            ptr_q <= wbus_q[CMD_PTR_LSB +: 8];
            go_q <= 1'b1;
          end
          HR_WDATA: begin
            if (wstrb_q[0]) wdata_q[7:0] <= wbus_q[7:0];
            if (wstrb_q[1]) wdata_q[15:8] <= wbus_q[15:8];
          end
          HR_TADDR: if (wstrb_q[0]) taddr_q <= wbus_q[6:0];
          HR_STATUS, HR_RDATA: S_AXI_BRESP_OUT <= RESP_OKAY;
          default: S_AXI_BRESP_OUT <= RESP_SLVERR;
        endcase
      end
    end
  end

  // AXI read side: one read at a time, answer one cycle after acceptance
  always_ff @(posedge CLOCK_IN) begin
    S_AXI_ARREADY_OUT <= 1'b0;
    if (!RST_N_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0000_0000;
      S_AXI_RRESP_OUT <= RESP_OKAY;
    end else if (S_AXI_RVALID_OUT) begin
      S_AXI_RVALID_OUT <= !S_AXI_RREADY_IN;
    end else if (S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT) begin
      // Data may only follow the address handshake, never lead it
      S_AXI_ARREADY_OUT <= 1'b1;
    end else if (S_AXI_ARVALID_IN) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RRESP_OUT <= RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        HR_CMD: S_AXI_RDATA_OUT <= {16'h0000, ptr_q, 6'h00, kind_q};
        HR_WDATA: S_AXI_RDATA_OUT <= {16'h0000, wdata_q};
        HR_TADDR: S_AXI_RDATA_OUT <= {25'h0000000, taddr_q};
        HR_STATUS: S_AXI_RDATA_OUT <= {30'h00000000, nack_q, st_q != H_IDLE};
        HR_RDATA: S_AXI_RDATA_OUT <= {16'h0000, rdata_q};
        default: begin
          S_AXI_RDATA_OUT <= 32'h0000_0000;
          S_AXI_RRESP_OUT <= RESP_SLVERR;
        end
      endcase
    end
  end

  // Three-stage sampling of the data line
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      sda_s_q <= 3'h7;
      sda_f_q <= 1'b1;
    end else begin
      sda_s_q <= {sda_s_q[1:0], LINK.sda};
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
    end
  end

  // Bit engine: four quarter periods per bit, clock divided from CLOCK_IN
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      st_q <= H_IDLE;
      qcnt_q <= 8'h00;
      q_q <= 2'b00;
      bit_q <= 4'h0;
      bi_q <= 3'd0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      nack_q <= 1'b0;
      rdata_q <= 16'h0000;
      scl_rel_q <= 1'b1;
      sda_rel_q <= 1'b1;
    end else if (go_q) begin
      st_q <= H_START;
      qcnt_q <= 8'h00;
      q_q <= 2'b00;
      bi_q <= 3'd0;
      nack_q <= 1'b0;
    end else if (st_q != H_IDLE) begin
      qcnt_q <= tick ? 8'h00 : qcnt_q + 8'h01;
      if (tick) begin
        q_q <= q_q + 2'b01;
        case (st_q)
          H_START: begin
            case (q_q)
              2'd0: sda_rel_q <= 1'b1;
              2'd1: scl_rel_q <= 1'b1;
              2'd2: sda_rel_q <= 1'b0;
              default: begin
                scl_rel_q <= 1'b0;
                st_q <= H_BYTE;
                bit_q <= 4'h0;
                sh_q <= byte_at(bi_q);
              end
            endcase
          end
          H_BYTE: begin
            case (q_q)
              2'd0: sda_rel_q <= bit_q != 4'h8 ? (rd_phase | sh_q[7]) : (!rd_phase | last_byte);
              2'd1: scl_rel_q <= 1'b1;
              2'd2: if (bit_q != 4'h8) begin
                rx_q <= {rx_q[6:0], sda_f_q};
                sh_q <= {sh_q[6:0], 1'b0};
              end else if (!rd_phase && sda_f_q) begin
                nack_q <= 1'b1;
              end
              default: begin
                scl_rel_q <= 1'b0;
                bit_q <= bit_q == 4'h8 ? 4'h0 : bit_q + 4'h1;
                if (bit_q == 4'h8) begin
                  if (bi_q == 3'd3 && rd_phase) rdata_q[15:8] <= rx_q;
                  if (bi_q == 3'd4) rdata_q[7:0] <= rx_q;
                  if (nack_q || last_byte) begin
                    st_q <= H_STOP;
                  end else if (kind_q == K_READ && bi_q == 3'd1) begin
                    st_q <= H_START;
                    bi_q <= 3'd2;
                  end else begin
                    bi_q <= bi_q + 3'd1;
                    sh_q <= byte_at(bi_q + 3'd1);
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            case (q_q)
              2'd0: sda_rel_q <= 1'b0;
              2'd1: scl_rel_q <= 1'b1;
              2'd2: sda_rel_q <= 1'b1;
              default: st_q <= H_IDLE;
            endcase
          end
          default: st_q <= H_IDLE;
        endcase
      end
    end
  end

  // Open-drain link drivers
  assign LINK.host_scl_o = 1'b0;
  assign LINK.host_scl_oe_n = scl_rel_q;
  assign LINK.host_sda_o = 1'b0;
  assign LINK.host_sda_oe_n = sda_rel_q;

endmodule

// >>> snt_props.sv
// Checker of the link between controller and target.
// Assumes bench clock, reset and the link signals.
`timescale 1ns/10ps
module snt_props (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // Link lines
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Target data held low for eight cycles once pulled
  sequence held_low_s; !dev_sda_oe_n [*8]; endsequence
  // Target drives only low, and pulls or lets go of data only while clock low
  open_drain_a: assert property (dev_sda_o == 1'b0) else $error("data high");
  bit_steady_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n)) else $error("moved");
  ack_hold_a: assert property ($fell(dev_sda_oe_n) |-> held_low_s) else $error("short");
  drive_start_a: assert property ($fell(dev_sda_oe_n) |-> !scl) else $error("late drive");
  release_low_a: assert property ($rose(dev_sda_oe_n) |-> !scl) else $error("late free");
  stop_idle_a: assert property (scl && $rose(sda) |=> dev_sda_oe_n [*8]) else $error("busy idle");
  // Clock shape, fast mode range
  clk_high_a: assert property ($rose(scl) |=> scl [*8]) else $error("high short");
  clk_low_a: assert property ($fell(scl) |-> ##[40:200] $rose(scl)) else $error("low long");
endmodule

// >>> sensor_i2c_target_with_nvm_load_bench.sv
// Bench: both ends on one link, commanded over AXI4-Lite.
// Assumes package, link, both ends and checker compiled first.
`timescale 1ns/10ps
module sensor_i2c_target_with_nvm_load_bench
  import snt_pkg::*;
;
  typedef struct {logic [1:0] k; logic [7:0] p; logic [15:0] d;} snt_row_s;
  // Reads expect the word in d
  snt_row_s rows [5] = '{'{K_WRITE, PTR_HIGH, 16'h1234}, '{K_READ, PTR_HIGH, 16'h1234},
    '{K_WRITE, PTR_LAST, 16'hbeef}, '{K_READ, PTR_LAST, 16'hbeef}, '{K_READ, PTR_TEMP, 16'h1a2b}};
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrd, arr, bvl, rvl, busy, unl;
  logic [1:0] brs, rrs;
  logic [3:0] stb = 4'hf;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000, rdt, v;
  logic [15:0] cfg;
  int failures = 0, n_tests = 0, cyc = 0;
  // Ends, link and checker
  snt_bus_if snt_bus_if_inst ();
  snt_target #(.LOAD_CYCLES(10500), .PROG_CYCLES(2000), .TIMEOUT_CYCLES(3000)) snt_target_inst (.CLOCK_IN(clk),
    .RST_N_IN(rst_n), .LINK(snt_bus_if_inst.dev), .ADDR_SEL_IN(2'h1), .TEMP_IN(16'h1a2b),
    .NVM_BUSY_OUT(busy), .NVM_UNLOCK_OUT(unl), .CONFIG_OUT(cfg));
  snt_controller snt_controller_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(stb), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd),
    .S_AXI_BRESP_OUT(brs), .S_AXI_BVALID_OUT(bvl), .S_AXI_BREADY_IN(bry), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdt), .S_AXI_RRESP_OUT(rrs), .S_AXI_RVALID_OUT(rvl), .S_AXI_RREADY_IN(rry),
    .LINK(snt_bus_if_inst.host));
  snt_props snt_props_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n), .scl(snt_bus_if_inst.scl), .sda(snt_bus_if_inst.sda),
    .dev_sda_o(snt_bus_if_inst.dev_sda_o), .dev_sda_oe_n(snt_bus_if_inst.dev_sda_oe_n));
  // 20 MHz clock
  always #25 clk = ~clk;
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Write: both channels offered, each dropped when taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bvl);
    v = {30'h0, brs};
    bry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    // Address dropped once taken; data taken at the edge it is seen
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rvl);
    v = rdt;
    rry <= 1'b0;
    @(posedge clk);
  endtask
  // One link transfer, polled to completion
  task automatic xfer(logic [1:0] k, logic [7:0] p, logic [15:0] d);
    wr(HR_WDATA, {16'h0000, d});
    wr(HR_CMD, {16'h0000, p, 6'h00, k});
    do rd(HR_STATUS); while (v[STAT_BUSY_BIT] !== 1'b0);
  endtask
  // Hang guard, a little above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer(K_POINTER, PTR_HIGH, 16'h0000);
    chk("nack", {15'h0, v[STAT_NACK_BIT]}, 16'h0001);
    wr(8'h20, 32'h00000000);
    chk("bresp", v[15:0], {14'h0, RESP_SLVERR});
    rd(8'h20);
    chk("rresp", {14'h0, rrs}, {14'h0, RESP_SLVERR});
    wr(HR_TADDR, 32'h00000049);
    xfer(K_WRITE, PTR_CFG, 16'h5555);
    chk("load", {15'h0, busy}, 16'h0001);
    chk("drop", cfg, REG_RESET);
    while (busy) @(posedge clk);
    chk("cfg", cfg, CFG_DEFAULT);
    foreach (rows[i]) begin
      xfer(rows[i].k, rows[i].p, rows[i].d);
      chk("locked", {15'h0, busy}, 16'h0000);
      if (rows[i].k == K_READ) begin
        rd(HR_RDATA);
        chk("word", v[15:0], rows[i].d);
      end
    end
    xfer(K_WRITE, PTR_UNLOCK, 16'h8000);
    chk("unlock", {15'h0, unl}, 16'h0001);
    xfer(K_WRITE, PTR_HIGH, 16'h5a5a);
    chk("prog", {15'h0, busy}, 16'h0001);
    while (busy) @(posedge clk);
    xfer(K_GCALL, 8'h00, 16'h0000);
    // Read served while the reload runs
    xfer(K_READ, PTR_HIGH, 16'h0000);
    rd(HR_RDATA);
    chk("stored", v[15:0], 16'h5a5a);
    chk("reloading", {15'h0, busy}, 16'h0001);
    while (busy) @(posedge clk);
    chk("relock", {15'h0, unl}, 16'h0000);
    // Word written only to the volatile copy comes back from the store
    xfer(K_READ, PTR_LAST, 16'h0000);
    rd(HR_RDATA);
    chk("reload", v[15:0], GP_DEFAULT);
    finish_test();
  end
endmodule
